// [include/peak_hold_pkg.sv]
/*
 Constants, offsets and the magnitude function shared by the peak hold
 and event status register slice.
 Assumes one processing clock; all inputs come from logic on that clock.
*/
package peak_hold_pkg;
   // register indices on the register port
   localparam logic [15:0] ADDR_PEAK_CURRENT = 16'h0400;
   localparam logic [15:0] ADDR_PEAK_VOLTAGE = 16'h0401;
   localparam logic [15:0] ADDR_EVENT_STATUS = 16'h0402;
   localparam logic [15:0] ADDR_PHASE_C_REGION = 16'h025d;

   // field layout
   localparam int VALUE_W = 24;
   localparam int PHASE_N = 3;
   localparam int PHASE_LSB = 24;
   localparam int SAMPLE_W = 29;
   localparam int PEAK_SHIFT = 5;
   localparam int TRIG_W = 11;
   localparam int MISMATCH_BIT = 24;
   localparam int BUF_FULL_BIT = 23;
   localparam int TRIG_BIT = 22;

   // reset and special values
   localparam logic [3:0] REGION_DISABLED = 4'hf;
   localparam logic [3:0] REGION_LAST = 4'h4;
   localparam logic [VALUE_W-1:0] PEAK_VALUE_RESET = 24'h000000;
   localparam logic [PHASE_N-1:0] PEAK_PHASE_RESET = 3'h0;
   localparam logic STATUS_RESET = 1'b0;
   localparam logic CAPTURE_RESAMPLED = 1'b0;

   // absolute value scaled down by two to the fifth
   function automatic logic [VALUE_W-1:0] peak_magnitude(
      input logic signed [SAMPLE_W-1:0] s);
      logic [SAMPLE_W-1:0] mag;
      mag = s[SAMPLE_W-1] ? (~s + 1'b1) : s;
      return mag[SAMPLE_W-1:PEAK_SHIFT];
   endfunction
endpackage

// [include/peak_if.sv]
/*
 Interface joining the register slice to one peak tracker.
 Assumes both ends share the processing clock.
*/
interface peak_if;
   import peak_hold_pkg::*;
   logic signed [SAMPLE_W-1:0] sample [PHASE_N];
   logic sample_valid;
   logic [PHASE_N-1:0] select;
   logic clear;
   logic [VALUE_W-1:0] value;
   logic [PHASE_N-1:0] phase;

   modport core (output sample, output sample_valid, output select, output clear,
      input value, input phase);
   modport tracker (input sample, input sample_valid, input select, input clear,
      output value, output phase);
endinterface

// [hdl/peak_tracker.sv]
/*
 Holds the largest scaled magnitude seen on the selected phases and the
 phases that produced it.
 Assumes samples, select and clear arrive on clk from the register slice.
*/
module peak_tracker
   import peak_hold_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // link to register slice
   peak_if.tracker p
);
   logic [VALUE_W-1:0] mag [PHASE_N];
   logic [VALUE_W-1:0] max_mag;
   logic [PHASE_N-1:0] hit;
   logic [VALUE_W-1:0] value;
   logic [PHASE_N-1:0] phase;
   wire load = p.sample_valid && (p.clear || max_mag > value);
   wire tie = p.sample_valid && !p.clear && max_mag == value && max_mag != '0;

   always_comb begin
      max_mag = '0;
      for (int i = 0; i < PHASE_N; i++) begin
         mag[i] = p.select[i] ? peak_magnitude(p.sample[i]) : '0;
         if (mag[i] > max_mag) begin
            max_mag = mag[i];
         end
      end
      for (int i = 0; i < PHASE_N; i++) begin
         hit[i] = p.select[i] && mag[i] == max_mag && max_mag != '0;
      end
   end

   // a clear with a sample restarts from that sample, so no peak is lost
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         value <= PEAK_VALUE_RESET;
         phase <= PEAK_PHASE_RESET;
      end else if (ce) begin
         if (load) begin
            value <= max_mag;
            phase <= hit;
         end else if (p.clear) begin
            value <= PEAK_VALUE_RESET;
            phase <= PEAK_PHASE_RESET;
         end else if (tie) begin
            phase <= phase | hit;
         end
      end
   end

   assign p.value = value;
   assign p.phase = phase;

   peak_grow_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && p.sample_valid && !p.clear |=> value >= $past(max_mag))
      else $error("peak value fell below a newer sample");
   peak_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      !(ce && (p.sample_valid || p.clear)) |=> $stable(value))
      else $error("peak value changed with no sample");
   peak_flag_a: assert property (@(posedge clk) disable iff (!nrst)
      value == '0 |-> phase == '0)
      else $error("phase flags set with zero peak");
endmodule // peak_tracker

// [hdl/peak_hold_and_status_regs.sv]
/*
 Register slice: phase C calibration region, peak current and voltage
 capture with source phase flags, and the upper event bits of the first
 status register, all on a simple indexed register port.
 Assumes all inputs are produced on clk by the metering core and that the
 serial port front end turns host frames into single-cycle strobes.
*/
// Behaviour
// - report active phase C calibration set 0..4
// - region reads 1111 when compensation off
// - hold 24-bit absolute peak current
// - peak equals full-rate sample over 32
// - three flags name phase of current peak
// - hold 24-bit absolute peak voltage over 32
// - bit 24 sets on sum/threshold relation change
// - bit 23 sets on resampled buffer full
// - bit 22 sets on enabled trigger event
module peak_hold_and_status_regs
   import peak_hold_pkg::*;
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // multipoint compensation
   input wire logic multipoint_comp_enable,
   input wire logic [3:0] active_region,
   // peak sources
   input wire logic signed [SAMPLE_W-1:0] fullrate_current_sample [PHASE_N],
   input wire logic signed [SAMPLE_W-1:0] fullrate_voltage_sample [PHASE_N],
   input wire logic sample_valid,
   input wire logic [2:0] peak_channel_select,
   // status event sources
   input wire logic [VALUE_W-1:0] current_sum_rms,
   input wire logic [VALUE_W-1:0] current_sum_threshold,
   input wire logic wave_buffer_full,
   input wire logic capture_source_select,
   input wire logic [TRIG_W-1:0] wave_trigger_events,
   input wire logic [TRIG_W-1:0] wave_trigger_config,
   // direct views
   output logic [3:0] phase_c_region_index,
   output logic current_sum_mismatch_flag,
   output logic resampled_buffer_full_flag,
   output logic wave_trigger_event_flag
);
   peak_if cur_if ();
   peak_if volt_if ();

   // address decode
   wire sel_cur = reg_addr == ADDR_PEAK_CURRENT;
   wire sel_volt = reg_addr == ADDR_PEAK_VOLTAGE;
   wire sel_stat = reg_addr == ADDR_EVENT_STATUS;
   wire sel_region = reg_addr == ADDR_PHASE_C_REGION;
   wire stat_wr = ce && reg_wr && sel_stat;

   // region: out-of-range index from the core is shown as disabled
   wire region_ok = active_region <= REGION_LAST;
   wire [3:0] next_region = (multipoint_comp_enable && region_ok) ? active_region
      : REGION_DISABLED;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_c_region_index <= REGION_DISABLED;
      end else if (ce) begin
         phase_c_region_index <= next_region;
      end
   end

   // peak capture; a read of a peak register restarts its hold
   assign cur_if.sample = fullrate_current_sample;
   assign cur_if.sample_valid = sample_valid;
   assign cur_if.select = peak_channel_select;
   assign cur_if.clear = reg_rd && sel_cur;
   assign volt_if.sample = fullrate_voltage_sample;
   assign volt_if.sample_valid = sample_valid;
   assign volt_if.select = peak_channel_select;
   assign volt_if.clear = reg_rd && sel_volt;

   peak_tracker cur_peak (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .p(cur_if.tracker)
   );

   peak_tracker volt_peak (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .p(volt_if.tracker)
   );

   // events; comparison is kept to see its changes
   logic sum_above;
   wire next_sum_above = current_sum_rms > current_sum_threshold;
   wire set_mismatch = next_sum_above != sum_above;
   wire set_full = wave_buffer_full && capture_source_select == CAPTURE_RESAMPLED;
   wire set_trig = |(wave_trigger_events & wave_trigger_config);
   wire clr_mismatch = stat_wr && reg_wdata[MISMATCH_BIT];
   wire clr_full = stat_wr && reg_wdata[BUF_FULL_BIT];
   wire clr_trig = stat_wr && reg_wdata[TRIG_BIT];

   // set wins over a clear in the same cycle
   wire next_mismatch = set_mismatch || (current_sum_mismatch_flag && !clr_mismatch);
   wire next_full = set_full || (resampled_buffer_full_flag && !clr_full);
   wire next_trig = set_trig || (wave_trigger_event_flag && !clr_trig);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sum_above <= 1'b0;
         current_sum_mismatch_flag <= STATUS_RESET;
         resampled_buffer_full_flag <= STATUS_RESET;
         wave_trigger_event_flag <= STATUS_RESET;
      end else if (ce) begin
         sum_above <= next_sum_above;
         current_sum_mismatch_flag <= next_mismatch;
         resampled_buffer_full_flag <= next_full;
         wave_trigger_event_flag <= next_trig;
      end
   end

   // read mux; unmapped and reserved bits read zero
   logic [31:0] status_word;
   logic [31:0] read_word;
   always_comb begin
      status_word = '0;
      status_word[MISMATCH_BIT] = current_sum_mismatch_flag;
      status_word[BUF_FULL_BIT] = resampled_buffer_full_flag;
      status_word[TRIG_BIT] = wave_trigger_event_flag;
      read_word = '0;
      if (sel_cur) begin
         read_word[PHASE_LSB +: PHASE_N] = cur_if.phase;
         read_word[VALUE_W-1:0] = cur_if.value;
      end else if (sel_volt) begin
         read_word[PHASE_LSB +: PHASE_N] = volt_if.phase;
         read_word[VALUE_W-1:0] = volt_if.value;
      end else if (sel_stat) begin
         read_word = status_word;
      end else if (sel_region) begin
         read_word[3:0] = phase_c_region_index;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else if (ce && reg_rd) begin
         reg_rdata <= read_word;
      end
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence clear_mismatch_s;
      stat_wr && reg_wdata[MISMATCH_BIT] && !set_mismatch;
   endsequence
   sequence hold_mismatch_s;
      current_sum_mismatch_flag && !(stat_wr && reg_wdata[MISMATCH_BIT]);
   endsequence

   region_off_a: assert property (ce && !multipoint_comp_enable
      |=> phase_c_region_index == REGION_DISABLED)
      else $error("region not disabled code");
   region_track_a: assert property (ce && multipoint_comp_enable && active_region <= REGION_LAST
      |=> phase_c_region_index == $past(active_region))
      else $error("region does not follow active set");
   region_range_a: assert property (phase_c_region_index <= REGION_LAST
      || phase_c_region_index == REGION_DISABLED)
      else $error("region code illegal");
   mismatch_set_a: assert property (ce && (current_sum_rms > current_sum_threshold) != sum_above
      |=> current_sum_mismatch_flag)
      else $error("mismatch not flagged");
   full_set_a: assert property (ce && wave_buffer_full && !capture_source_select
      |=> resampled_buffer_full_flag)
      else $error("buffer full not flagged");
   full_gate_a: assert property (ce && !resampled_buffer_full_flag && capture_source_select
      |=> !resampled_buffer_full_flag)
      else $error("buffer full flagged for fixed rate capture");
   trig_set_a: assert property (ce && |(wave_trigger_events & wave_trigger_config)
      |=> wave_trigger_event_flag)
      else $error("trigger event not flagged");
   w1c_clear_a: assert property (ce and clear_mismatch_s |=> !current_sum_mismatch_flag)
      else $error("write one did not clear");
   w0_hold_a: assert property (ce and hold_mismatch_s |=> current_sum_mismatch_flag)
      else $error("flag lost without write one");
   reserved_zero_a: assert property (ce && reg_rd && sel_stat
      |=> reg_rdata[31:25] == 7'h00 && reg_rdata[21:0] == 22'h0)
      else $error("reserved status bits not zero");
   peak_read_a: assert property (ce && reg_rd && sel_cur ##0 !sample_valid
      |=> reg_rdata[23:0] == $past(cur_if.value) ##0 cur_if.value == 24'h0)
      else $error("peak read wrong or not restarted");

   sequence mismatch_and_clear_s;
      set_mismatch && clr_mismatch;
   endsequence
   set_wins_a: assert property (ce and mismatch_and_clear_s |=> current_sum_mismatch_flag)
      else $error("write one beat a new mismatch");
   trig_gate_a: assert property (ce && !wave_trigger_event_flag
      && (wave_trigger_events & wave_trigger_config) == '0 |=> !wave_trigger_event_flag)
      else $error("trigger flag set by a disabled event");
   flag_freeze_a: assert property (!ce |=> $stable(current_sum_mismatch_flag)
      && $stable(resampled_buffer_full_flag) && $stable(wave_trigger_event_flag))
      else $error("status flag moved with clock enable low");
   region_read_a: assert property (ce && reg_rd && sel_region
      |=> reg_rdata == {28'h0, $past(phase_c_region_index)})
      else $error("region read wrong");
   region_freeze_a: assert property (!ce |=> $stable(phase_c_region_index)
      && $stable(reg_rdata))
      else $error("region or read data moved with clock enable low");
   volt_read_a: assert property (ce && reg_rd && sel_volt ##0 !sample_valid
      |=> reg_rdata[23:0] == $past(volt_if.value) ##0 volt_if.value == 24'h0)
      else $error("voltage peak read wrong or not restarted");
endmodule // peak_hold_and_status_regs

// [tb/host_model.sv]
/*
 Host side of the register port: indexed reads and write-one-clear writes.
 Assumes one-cycle strobes launched at the falling edge of clk.
*/
module host_model (
   // clock
   input wire logic clk,
   // register port
   output logic [15:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_addr = 16'hffff;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 32'h0;
   end
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
      // idle address never repeats the last one
      reg_addr = ~a;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule // host_model

// [tb/peak_hold_and_status_regs_tb.sv]
/*
 Self-checking bench for the peak hold and event status register slice.
 Assumes host_model drives the register port; everything else from here.
*/
module peak_hold_and_status_regs_tb import peak_hold_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] reg_addr;
   logic reg_rd, reg_wr;
   logic [31:0] reg_wdata, reg_rdata;
   logic mc_en = 1'b0;
   logic [3:0] region = 4'h0;
   logic signed [SAMPLE_W-1:0] isamp [PHASE_N] = '{default: '0};
   logic signed [SAMPLE_W-1:0] vsamp [PHASE_N] = '{default: '0};
   logic valid = 1'b0;
   logic ce = 1'b1;
   logic [2:0] sel = 3'h0;
   logic [VALUE_W-1:0] rms = 24'h0, thr = 24'h0;
   logic wfull = 1'b0, capsel = 1'b1;
   logic [TRIG_W-1:0] tev = 11'h0, tcfg = 11'h008;
   logic [3:0] region_idx;
   logic f24, f23, f22;
   int mismatches = 0;
   int tests_run = 0;
   always #25 clk = ~clk;
   host_model host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   peak_hold_and_status_regs dut (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .multipoint_comp_enable(mc_en), .active_region(region),
      .fullrate_current_sample(isamp), .fullrate_voltage_sample(vsamp),
      .sample_valid(valid), .peak_channel_select(sel), .current_sum_rms(rms),
      .current_sum_threshold(thr), .wave_buffer_full(wfull),
      .capture_source_select(capsel), .wave_trigger_events(tev),
      .wave_trigger_config(tcfg), .phase_c_region_index(region_idx),
      .current_sum_mismatch_flag(f24), .resampled_buffer_full_flag(f23),
      .wave_trigger_event_flag(f22));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] d;
      host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic pulse(input int i0, i1, i2, v0, v1, v2);
      @(negedge clk);
      isamp = '{SAMPLE_W'(i0), SAMPLE_W'(i1), SAMPLE_W'(i2)};
      vsamp = '{SAMPLE_W'(v0), SAMPLE_W'(v1), SAMPLE_W'(v2)};
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
   endtask
   task automatic results;
      if (mismatches == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // about seventy cycles expected; seventy times that is a hang
   initial begin
      #250000;
      mismatches++;
      results();
   end
   initial begin
      #100 nrst = 1'b1;
      chk({28'h0, region_idx}, {28'h0, REGION_DISABLED});
      rdchk(ADDR_PEAK_CURRENT, 32'h0);
      rdchk(ADDR_PEAK_VOLTAGE, 32'h0);
      rdchk(ADDR_EVENT_STATUS, 32'h0);
      rdchk(ADDR_PHASE_C_REGION, 32'hf);
      mc_en = 1'b1;
      for (int r = 0; r <= 5; r++) begin
         region = r[3:0];
         rdchk(ADDR_PHASE_C_REGION, (r < 5) ? r : 32'hf);
      end
      region = 4'h2;
      rdchk(ADDR_PHASE_C_REGION, 32'h2);
      mc_en = 1'b0;
      rdchk(ADDR_PHASE_C_REGION, 32'hf);
      chk({28'h0, region_idx}, 32'hf);
      // phase C left out: its larger magnitude must not win
      sel = 3'b011;
      pulse(-(100 * 32 + 31), 50 * 32, 1000 * 32, 32, 2 * 32, -(9 * 32));
      pulse(10 * 32, 3 * 32, 0, 0, 0, 0);
      rdchk(ADDR_PEAK_CURRENT, {5'h0, 3'b001, 24'd100});
      rdchk(ADDR_PEAK_VOLTAGE, {5'h0, 3'b010, 24'd2});
      sel = 3'b111;
      pulse(7 * 32, -(7 * 32), 5 * 32, 32, 2 * 32, -(9 * 32 + 5));
      rdchk(ADDR_PEAK_CURRENT, {5'h0, 3'b011, 24'd7});
      rdchk(ADDR_PEAK_VOLTAGE, {5'h0, 3'b100, 24'd9});
      rdchk(ADDR_PEAK_CURRENT, 32'h0);
      // events that must not set: wrong capture source, disabled trigger
      pulse(0, 0, 0, 0, 0, 0);
      wfull = 1'b1;
      tev = 11'h020;
      @(negedge clk);
      wfull = 1'b0;
      tev = 11'h0;
      rdchk(ADDR_EVENT_STATUS, 32'h0);
      rms = 24'h5;
      thr = 24'h3;
      capsel = CAPTURE_RESAMPLED;
      wfull = 1'b1;
      tev = 11'h028;
      @(negedge clk);
      wfull = 1'b0;
      tev = 11'h0;
      rdchk(ADDR_EVENT_STATUS, 32'h01c00000);
      chk({29'h0, f24, f23, f22}, 32'h7);
      host.wr(ADDR_EVENT_STATUS, 32'hfe3fffff);
      host.wr(ADDR_PEAK_CURRENT, 32'hffffffff);
      rdchk(ADDR_EVENT_STATUS, 32'h01c00000);
      host.wr(ADDR_EVENT_STATUS, 32'h00800000);
      rdchk(ADDR_EVENT_STATUS, 32'h01400000);
      host.wr(ADDR_EVENT_STATUS, 32'hffffffff);
      rdchk(ADDR_EVENT_STATUS, 32'h0);
      rdchk(16'h0123, 32'h0);
      thr = 24'h9;
      rdchk(ADDR_EVENT_STATUS, 32'h01000000);
      // clock enable low: a buffer-full event must wait for it
      ce = 1'b0;
      wfull = 1'b1;
      @(negedge clk);
      chk({31'h0, f23}, 32'h0);
      ce = 1'b1;
      @(negedge clk);
      wfull = 1'b0;
      chk({31'h0, f23}, 32'h1);
      results();
   end
endmodule // peak_hold_and_status_regs_tb
